/* hdl/ips_consts.vh */
// Constants for the IIR product-sum unit
// Assumes inclusion by bare name from the unit's design files
`ifndef IPS_CONSTS_VH
`define IPS_CONSTS_VH

// ==========================================================
// Data widths
`define IPS_DW        16
`define IPS_AW        40
`define IPS_MEMW      4

// ==========================================================
// Storage select codes for the load port
`define IPS_SEL_A     2'h0
`define IPS_SEL_B     2'h1
`define IPS_SEL_X     2'h2
`define IPS_SEL_Y     2'h3

// ==========================================================
// Scaling and clipping
`define IPS_FRAC      5'h0F
`define IPS_SH12      5'h13
`define IPS_SH10      5'h15
`define IPS_MAX16     40'h0000007FFF
`define IPS_MAX12     40'h00000007FF
`define IPS_MAX10     40'h00000001FF

// ==========================================================
// Reset values
`define IPS_RES_RST   16'h0000
`define IPS_ACC_RST   40'h0000000000

`endif

/* hdl/ips_sat.v */
// Round and clip stage of the IIR product-sum unit
// Assumes a signed accumulator with fifteen fraction bits; purely combinational
`timescale 1ns/1ps
`include "ips_consts.vh"

module ips_sat (
  acc,
  rnd_en,
  width12,
  res
);
  input  wire signed [39:0] acc;
  input  wire               rnd_en;
  input  wire               width12;
  output reg         [15:0] res;

  reg         [4:0]  sh;
  reg  signed [39:0] rnd;
  reg  signed [39:0] shv;
  reg  signed [39:0] lim;

  // ========================================================
  // Rounding, scaling and saturation
  always @* begin
    sh  = rnd_en ? (width12 ? `IPS_SH12 : `IPS_SH10) : `IPS_FRAC;
    lim = rnd_en ? (width12 ? `IPS_MAX12 : `IPS_MAX10) : `IPS_MAX16;
    rnd = acc;
    if (rnd_en) begin
      rnd = acc + (40'sh0000000001 <<< (sh - 5'h01));
    end
    shv = rnd >>> sh;
    if (shv > lim) begin
      shv = lim;
    end else if (shv < -lim - 40'sh0000000001) begin
      shv = -lim - 40'sh0000000001;
    end
    res = shv[15:0];
  end

endmodule // ips_sat

/* hdl/ips_core.v */
// IIR product-sum engine: four banks of coefficients and variables
// Assumes load port and control come from logic on ref_clk; one clock, async reset
//
// Contract
// - Result is sum of B times Y plus sum of A times X.
// - Operands are 16-bit; storage is four independent banks.
// - B.Y terms and A.X terms each programmable from one to four.
// - Optional rounding and saturation to 10 or 12 bits.
// - Concatenated banks pass each section result to the next bank's variables.
// - Operation takes (M+N+1) times B plus 1 clock cycles.
`timescale 1ns/1ps
`include "ips_consts.vh"

module ips_core (
  ref_clk,
  rst,
  ld_en,
  ld_sel,
  ld_bank,
  ld_idx,
  ld_data,
  start,
  m_terms,
  n_terms,
  num_banks,
  cascade_en,
  rnd_en,
  width12,
  busy_ff,
  done_ff,
  result_ff
);
  // ========================================================
  // Clock, reset, load port and control inputs
  input  wire        ref_clk;
  input  wire        rst;
  input  wire        ld_en;
  input  wire [1:0]  ld_sel;
  input  wire [1:0]  ld_bank;
  input  wire [1:0]  ld_idx;
  input  wire [15:0] ld_data;
  input  wire        start;
  input  wire [1:0]  m_terms;
  input  wire [1:0]  n_terms;
  input  wire [1:0]  num_banks;
  input  wire        cascade_en;
  input  wire        rnd_en;
  input  wire        width12;

  // ========================================================
  // Status and result outputs
  output reg         busy_ff;
  output reg         done_ff;
  output reg  [15:0] result_ff;

  // ========================================================
  // Sequencer states, one-hot
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_MAC  = 4'h2;
  localparam [3:0] ST_SEC  = 4'h4;
  localparam [3:0] ST_LAST = 4'h8;

  // ========================================================
  // Operand storage, one array per operand kind
  reg         [15:0] mem_a [0:15];
  reg         [15:0] mem_b [0:15];
  reg         [15:0] mem_x [0:15];
  reg         [15:0] mem_y [0:15];

  // ========================================================
  // Sequencer state and configuration captured at start
  reg         [3:0]  state_ff;
  reg         [1:0]  bank_ff;
  reg         [2:0]  term_ff;
  reg  signed [39:0] acc_ff;
  reg         [1:0]  m_ff;
  reg         [1:0]  n_ff;
  reg         [1:0]  nb_ff;
  reg                casc_ff;
  reg                rnd_ff;
  reg                w12_ff;

  // ========================================================
  // Datapath nets
  reg                is_b;
  reg         [1:0]  idx;
  reg  signed [31:0] prod;
  wire        [15:0] sec_res;
  wire        [1:0]  nxt_bank;
  wire               last_term;

  // ========================================================
  // Storage address: bank in upper bits, term in lower bits
  function [3:0] fn_addr;
    input [1:0] bank;
    input [1:0] pos;
    begin
      fn_addr = {bank, pos};
    end
  endfunction

  // ========================================================
  // Bank stepping and end of section
  assign nxt_bank  = bank_ff + 2'h1;
  assign last_term = (term_ff == ({1'b0, m_ff} + {1'b0, n_ff} + 3'h1));

  // ========================================================
  // Term selection and product
  always @* begin
    is_b = (term_ff <= {1'b0, m_ff});
    idx  = is_b ? term_ff[1:0] : (term_ff[1:0] - m_ff - 2'h1);
    if (is_b) begin
      prod = $signed(mem_b[fn_addr(bank_ff, idx)])
           * $signed(mem_y[fn_addr(bank_ff, idx)]);
    end else begin
      prod = $signed(mem_a[fn_addr(bank_ff, idx)])
           * $signed(mem_x[fn_addr(bank_ff, idx)]);
    end
  end

  // ========================================================
  // Round and clip of the section sum
  ips_sat u_sat (
    .acc     (acc_ff),
    .rnd_en  (rnd_ff),
    .width12 (w12_ff),
    .res     (sec_res)
  );

  // ========================================================
  // Storage writes: load port when idle, cascade when running
  always @(posedge ref_clk) begin
    if (ld_en && (state_ff == ST_IDLE)) begin
      case (ld_sel)
        `IPS_SEL_A: begin
          mem_a[fn_addr(ld_bank, ld_idx)] <= ld_data;
        end
        `IPS_SEL_B: begin
          mem_b[fn_addr(ld_bank, ld_idx)] <= ld_data;
        end
        `IPS_SEL_X: begin
          mem_x[fn_addr(ld_bank, ld_idx)] <= ld_data;
        end
        default: begin
          mem_y[fn_addr(ld_bank, ld_idx)] <= ld_data;
        end
      endcase
    end else if ((state_ff == ST_SEC) && casc_ff && (bank_ff != nb_ff)) begin
      mem_x[fn_addr(nxt_bank, 2'h3)] <= mem_x[fn_addr(nxt_bank, 2'h2)];
      mem_x[fn_addr(nxt_bank, 2'h2)] <= mem_x[fn_addr(nxt_bank, 2'h1)];
      mem_x[fn_addr(nxt_bank, 2'h1)] <= mem_x[fn_addr(nxt_bank, 2'h0)];
      mem_x[fn_addr(nxt_bank, 2'h0)] <= sec_res;
    end
  end

  // ========================================================
  // Sequencer
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff  <= ST_IDLE;
      bank_ff   <= 2'h0;
      term_ff   <= 3'h0;
      acc_ff    <= `IPS_ACC_RST;
      m_ff      <= 2'h0;
      n_ff      <= 2'h0;
      nb_ff     <= 2'h0;
      casc_ff   <= 1'b0;
      rnd_ff    <= 1'b0;
      w12_ff    <= 1'b0;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      result_ff <= `IPS_RES_RST;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            m_ff     <= m_terms;
            n_ff     <= n_terms;
            nb_ff    <= num_banks;
            casc_ff  <= cascade_en;
            rnd_ff   <= rnd_en;
            w12_ff   <= width12;
            bank_ff  <= 2'h0;
            term_ff  <= 3'h0;
            acc_ff   <= `IPS_ACC_RST;
            busy_ff  <= 1'b1;
            state_ff <= ST_MAC;
          end
        end
        ST_MAC: begin
          acc_ff  <= acc_ff + {{8{prod[31]}}, prod};
          term_ff <= term_ff + 3'h1;
          if (last_term) begin
            state_ff <= ST_SEC;
          end
        end
        ST_SEC: begin
          result_ff <= sec_res;
          acc_ff    <= `IPS_ACC_RST;
          term_ff   <= 3'h0;
          if (bank_ff == nb_ff) begin
            state_ff <= ST_LAST;
          end else begin
            bank_ff  <= nxt_bank;
            state_ff <= ST_MAC;
          end
        end
        ST_LAST: begin
          busy_ff  <= 1'b0;
          done_ff  <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
          busy_ff  <= 1'b0;
        end
      endcase
    end
  end

endmodule // ips_core

/* hdl/ips_core_dummy_never.v */
// Holds no logic: the unit is ips_core with its round and clip stage ips_sat
// Assumes nothing of its surroundings

/* verif/ips_core_assertions.sv */
// Checker for the IIR product-sum unit
// Assumes binding to the ports of ips_core
`timescale 1ns/1ps
module ips_core_chk (
  input wire        ref_clk,
  input wire        rst,
  input wire        start,
  input wire [1:0]  m_terms,
  input wire [1:0]  n_terms,
  input wire [1:0]  num_banks,
  input wire        busy_ff,
  input wire        done_ff,
  input wire [15:0] result_ff
);
  // ====
  // Cycle count since accepted start
  reg [5:0] cnt_ff;
  reg [5:0] exp_ff;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_take;
    start && !busy_ff;
  endsequence
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 6'h00;
      exp_ff <= 6'h00;
    end else if (start && !busy_ff) begin
      cnt_ff <= 6'h00;
      exp_ff <= ({4'h0, m_terms} + {4'h0, n_terms} + 6'h03) * ({4'h0, num_banks} + 6'h01) + 6'h01;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end
  // ====
  // Properties
  a_exact_len: assert property (done_ff |-> cnt_ff == exp_ff)
    else $error("operation length wrong");
  a_take_busy: assert property (s_take |=> busy_ff)
    else $error("start not taken");
  a_busy_min: assert property (s_take |=> busy_ff [*4])
    else $error("busy too short");
  a_done_bound: assert property (s_take |-> ##[5:38] done_ff)
    else $error("done missing");
  a_done_pulse: assert property (done_ff |=> !done_ff)
    else $error("done too long");
  a_done_ends: assert property (done_ff |-> !busy_ff && $past(busy_ff))
    else $error("done without busy end");
  a_idle_hold: assert property (!busy_ff |=> $stable(result_ff))
    else $error("result moved while idle");
  a_busy_cause: assert property ($rose(busy_ff) |-> $past(start))
    else $error("busy without start");
endmodule // ips_core_chk

/* verif/iir_product_sum_unit_bench.sv */
// Self-checking bench for the IIR product-sum unit
// Assumes ips_core and its checker are compiled first
`timescale 1ns/1ps
module iir_product_sum_unit_bench;
  reg         ref_clk, rst, ld_en, start, cascade_en, rnd_en, width12;
  reg  [1:0]  ld_sel, ld_bank, ld_idx, m_terms, n_terms, num_banks;
  reg  [15:0] ld_data;
  wire        busy_ff, done_ff;
  wire [15:0] result_ff;
  integer     fail_count, cmp_count, cnt, i;
  ips_core dut (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .ld_en      (ld_en),
    .ld_sel     (ld_sel),
    .ld_bank    (ld_bank),
    .ld_idx     (ld_idx),
    .ld_data    (ld_data),
    .start      (start),
    .m_terms    (m_terms),
    .n_terms    (n_terms),
    .num_banks  (num_banks),
    .cascade_en (cascade_en),
    .rnd_en     (rnd_en),
    .width12    (width12),
    .busy_ff    (busy_ff),
    .done_ff    (done_ff),
    .result_ff  (result_ff)
  );
  // ====
  // Tasks
  task chk(input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (fail_count == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task ld(input [1:0] s, input [1:0] b, input [1:0] x, input [15:0] d);
    begin
      @(negedge ref_clk);
      {ld_en, ld_sel, ld_bank, ld_idx, ld_data} = {1'h1, s, b, x, d};
      @(negedge ref_clk);
      ld_en = 1'h0;
    end
  endtask
  task fill(input [15:0] d);
    begin
      for (i = 0; i < 16; i = i + 1) begin
        ld(i[3:2], 2'h0, i[1:0], d);
      end
    end
  endtask
  task ld4(input [15:0] b, input [15:0] y, input [15:0] a, input [15:0] x);
    begin
      ld(2'h1, 2'h0, 2'h0, b);
      ld(2'h3, 2'h0, 2'h0, y);
      ld(2'h0, 2'h0, 2'h0, a);
      ld(2'h2, 2'h0, 2'h0, x);
    end
  endtask
  task rst_mid;
    begin
      @(negedge ref_clk);
      {m_terms, n_terms, num_banks, cascade_en, rnd_en, width12} = 9'h1E0;
      start = 1'h1;
      @(negedge ref_clk);
      start = 1'h0;
      repeat (3) @(negedge ref_clk);
      rst = 1'h1;
      @(negedge ref_clk);
      chk({14'h0, busy_ff, done_ff}, 16'h0000);
      chk(result_ff, 16'h0000);
      rst = 1'h0;
      @(negedge ref_clk);
      chk({14'h0, busy_ff, done_ff}, 16'h0000);
    end
  endtask
  task run(input [1:0] m, input [1:0] n, input [1:0] b, input [2:0] opt, input [15:0] exp);
    begin
      @(negedge ref_clk);
      {m_terms, n_terms, num_banks, cascade_en, rnd_en, width12} = {m, n, b, opt};
      start = 1'h1;
      @(negedge ref_clk);
      start = 1'h0;
      chk({15'h0, busy_ff}, 16'h0001);
      @(negedge ref_clk);
      {start, ld_en, ld_sel, ld_bank, ld_idx, ld_data} = {2'h3, 6'h00, 16'h0000};
      @(negedge ref_clk);
      {start, ld_en} = 2'h0;
      cnt = 3;
      while (done_ff !== 1'h1 && cnt < 60) begin
        @(negedge ref_clk);
        cnt = cnt + 1;
      end
      chk(cnt[15:0], ({14'h0, m} + n + 16'h3) * (b + 16'h1) + 16'h2);
      chk(result_ff, exp);
      chk({15'h0, busy_ff}, 16'h0000);
      @(negedge ref_clk);
      chk({15'h0, done_ff}, 16'h0000);
    end
  endtask
  // ====
  // Clock, sequence, watchdog
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    {rst, ld_en, start, cascade_en, rnd_en, width12} = 6'h20;
    {ld_sel, ld_bank, ld_idx, m_terms, n_terms, num_banks} = 12'h000;
    ld_data = 16'h0000;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'h0;
    chk(result_ff, 16'h0000);
    chk({14'h0, busy_ff, done_ff}, 16'h0000);
    fill(16'h1000);
    run(2'h3, 2'h3, 2'h0, 3'h0, 16'h1000);
    run(2'h3, 2'h3, 2'h0, 3'h3, 16'h0100);
    run(2'h3, 2'h3, 2'h0, 3'h2, 16'h0040);
    fill(16'h7FFF);
    run(2'h3, 2'h3, 2'h0, 3'h0, 16'h7FFF);
    run(2'h3, 2'h3, 2'h0, 3'h3, 16'h07FF);
    run(2'h3, 2'h3, 2'h0, 3'h2, 16'h01FF);
    fill(16'h4000);
    run(2'h0, 2'h0, 2'h0, 3'h0, 16'h4000);
    ld(2'h0, 2'h1, 2'h0, 16'h4000);
    ld(2'h1, 2'h1, 2'h0, 16'h0000);
    ld(2'h2, 2'h1, 2'h0, 16'h1000);
    ld(2'h3, 2'h1, 2'h0, 16'h0000);
    run(2'h0, 2'h0, 2'h1, 3'h0, 16'h0800);
    run(2'h0, 2'h0, 2'h1, 3'h4, 16'h2000);
    rst_mid;
    ld4(16'h8000, 16'h7FFF, 16'h8000, 16'h7FFF);
    run(2'h0, 2'h0, 2'h0, 3'h0, 16'h8000);
    run(2'h0, 2'h0, 2'h0, 3'h3, 16'hF800);
    run(2'h0, 2'h0, 2'h0, 3'h2, 16'hFE00);
    ld4(16'h4000, 16'h4000, 16'h0040, 16'h1000);
    run(2'h0, 2'h0, 2'h0, 3'h3, 16'h0201);
    run(2'h0, 2'h0, 2'h0, 3'h0, 16'h2008);
    fill(16'h1000);
    ld(2'h1, 2'h0, 2'h2, 16'h7FFF);
    ld(2'h0, 2'h0, 2'h3, 16'h7FFF);
    run(2'h1, 2'h2, 2'h0, 3'h0, 16'h0A00);
    report_and_stop;
  end
  initial begin
    #(3000 * 100);
    fail_count = fail_count + 1;
    report_and_stop;
  end
endmodule // iir_product_sum_unit_bench
bind ips_core ips_core_chk u_chk (
  .ref_clk   (ref_clk),
  .rst       (rst),
  .start     (start),
  .m_terms   (m_terms),
  .n_terms   (n_terms),
  .num_banks (num_banks),
  .busy_ff   (busy_ff),
  .done_ff   (done_ff),
  .result_ff (result_ff)
);
